//--- verilog/rob_pkg.sv
package rob_pkg;

   // ***************************************************************
   // Socket map
   // ***************************************************************
   localparam int           SOCKET_COUNT    = 16;
   localparam int           STRAP_COUNT     = 9;
   localparam int           ADDR_WIDTH      = 16;
   localparam int           EPROM_ADDR_BITS = 11;
   // Window of the overlay in program space, upper address bits
   localparam logic [ 3:0]  BASE_TOP_PLAIN  = 4'h0;
   localparam logic [ 3:0]  BASE_TOP_ALT    = 4'h8;
   // Delay from arming to transceiver enable, in bus clocks
   localparam logic [ 2:0]  ENABLE_DELAY    = 3'h4;
   localparam logic [ 2:0]  COUNT_RESET     = 3'h0;

   // Response sequence
   typedef enum logic [1:0] {
      ROB_IDLE,
      ROB_ARMED,
      ROB_ENDING,
      ROB_RELEASE
   } rob_state_type;

   typedef struct packed {
      rob_state_type                state;
      logic [2:0]                   count;
      logic                         bdd_sync1;
      logic                         bdd_sync2;
      logic                         as_sync1;
      logic                         as_sync2;
      logic                         ds_sync1;
      logic                         ds_sync2;
      logic [ADDR_WIDTH-1:0]        addr_sync1;
      logic [ADDR_WIDTH-1:0]        addr_sync2;
      logic [SOCKET_COUNT-1:0]      chip_select_n;
      logic                         xcvr_enable;
      logic                         bdd_oe_n;
   } rob_regs_type;

endpackage : rob_pkg

//--- verilog/rob_responder.sv
// Functional notes
// - Assert board data disable low when a fitted overlay EPROM is addressed.
// - Drive each socket chip select when its range is addressed, fitted or not.
// - Each 4K processor ROM 1 to 7 maps to two 2K EPROMs; ROMs 0 and 8 map to one.
// - Transceiver only enabled for straps present; absent sockets still get their chip select.
// - Processor-asserted disable marks a patch; leave transceiver off.
// - Sample inactive high disable level into the response flip-flop to arm.
// - Four clocks after arming, enable transceiver if strobe low and armed.
// - On the arming clock, board itself asserts board data disable.
// - Address strobe enables decode; response flip-flop held clear while strobe high.
// - One clock after data strobe rises, clear the delay counter.
// - One more clock later, remove the transceiver enable.
// - Placement straps a and b choose address window, strap c swaps socket order; presence straps ORed into transceiver control.
`timescale 1ns/100ps
module rob_responder (
   input  wire logic                                clk,
   input  wire logic                                arst_n,
   input  wire logic [rob_pkg::ADDR_WIDTH-1:0]      bus_addr,
   input  wire logic                                address_strobe_n,
   input  wire logic                                data_strobe_n,
   input  wire logic                                board_data_disable_n_in,
   input  wire logic [rob_pkg::STRAP_COUNT-1:0]     eprom_presence_straps,
   input  wire logic                                address_placement_strap_a,
   input  wire logic                                address_placement_strap_b,
   input  wire logic                                address_placement_strap_c,
   output logic                                     board_data_disable_n_out,
   output logic                                     board_data_disable_n_oe_n,
   output logic [rob_pkg::SOCKET_COUNT-1:0]         eprom_chip_select_n,
   output logic                                     data_xcvr_enable
);

   // ***************************************************************
   // State
   // ***************************************************************
   rob_pkg::rob_regs_type r_q;
   rob_pkg::rob_regs_type r_d;

   logic [3:0]                      base_top;
   logic [3:0]                      socket;
   logic                            in_window;
   logic                            fitted;
   logic [rob_pkg::STRAP_COUNT-1:0] strap_hit;

   // Placement straps pick the window; strap_c is a socket-order swap
   always_comb begin
      base_top  = address_placement_strap_a ? rob_pkg::BASE_TOP_ALT
                                            : rob_pkg::BASE_TOP_PLAIN;
      if (address_placement_strap_b) begin
         base_top = base_top ^ 4'h4;
      end
      in_window = (r_q.addr_sync2[15] == base_top[3])
                  && (r_q.addr_sync2[14] == base_top[2]);
      socket    = r_q.addr_sync2[14:11] ^ {3'h0, address_placement_strap_c};
      socket    = {2'h0, r_q.addr_sync2[12:11]} | {r_q.addr_sync2[14:13], 2'h0};
      socket[0] = socket[0] ^ address_placement_strap_c;
   end

   // ROM 0 (2K) owns socket 0 and strap 0; ROMs 1 to 7 each own a socket pair, ROM 8 owns socket 15 alone
   always_comb begin
      strap_hit = '0;
      if (socket == 4'h0) begin
         strap_hit[0] = 1'b1;
      end else begin
         // Pair index kept four bits wide so socket 15 reaches strap 8, no wrap
         strap_hit[{1'b0, socket[3:1]} + {3'h0, socket[0]}] = 1'b1;
      end
      fitted = |(strap_hit & eprom_presence_straps);
   end

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      r_d            = r_q;
      r_d.bdd_sync1  = board_data_disable_n_in;
      r_d.bdd_sync2  = r_q.bdd_sync1;
      r_d.as_sync1   = address_strobe_n;
      r_d.as_sync2   = r_q.as_sync1;
      r_d.ds_sync1   = data_strobe_n;
      r_d.ds_sync2   = r_q.ds_sync1;
      r_d.addr_sync1 = bus_addr;
      r_d.addr_sync2 = r_q.addr_sync1;

      // Selects follow the strobe for every socket, fitted or not
      r_d.chip_select_n = '1;
      if (!r_q.as_sync2 && in_window) begin
         r_d.chip_select_n[socket] = 1'b0;
      end

      case (r_q.state)
         rob_pkg::ROB_IDLE: begin
            r_d.count       = rob_pkg::COUNT_RESET;
            r_d.xcvr_enable = 1'b0;
            r_d.bdd_oe_n    = 1'b1;
            // Own drive excluded so we only see the processor card's patch claim
            if (!r_q.as_sync2 && in_window && fitted && r_q.bdd_sync2) begin
               r_d.state    = rob_pkg::ROB_ARMED;
               r_d.bdd_oe_n = 1'b0;
            end
         end
         rob_pkg::ROB_ARMED: begin
            if (r_q.count != rob_pkg::ENABLE_DELAY) begin
               r_d.count = r_q.count + 3'h1;
            end
            if (r_q.count == rob_pkg::ENABLE_DELAY - 3'h1) begin
               r_d.xcvr_enable = 1'b1;
            end
            if (!r_q.ds_sync2) begin
               r_d.state = rob_pkg::ROB_ENDING;
            end
         end
         rob_pkg::ROB_ENDING: begin
            // Wait for the data strobe to finish the read
            if (r_q.count != rob_pkg::ENABLE_DELAY) begin
               r_d.count = r_q.count + 3'h1;
            end
            if (r_q.count == rob_pkg::ENABLE_DELAY - 3'h1) begin
               r_d.xcvr_enable = 1'b1;
            end
            if (r_q.ds_sync2) begin
               r_d.count = rob_pkg::COUNT_RESET;
               r_d.state = rob_pkg::ROB_RELEASE;
            end
         end
         rob_pkg::ROB_RELEASE: begin
            // Stay here until the address strobe rises, so one strobe gives one answer
            r_d.xcvr_enable = 1'b0;
            r_d.bdd_oe_n    = 1'b1;
         end
         default: begin
            r_d.state = rob_pkg::ROB_IDLE;
         end
      endcase

      // Strobe high holds the response clear; bus turns free at once
      if (r_q.as_sync2 && r_q.state != rob_pkg::ROB_IDLE) begin
         r_d.state       = rob_pkg::ROB_IDLE;
         r_d.count       = rob_pkg::COUNT_RESET;
         r_d.xcvr_enable = 1'b0;
         r_d.bdd_oe_n    = 1'b1;
      end
      // Transceiver needs strobe low as well as the armed flip-flop
      if (r_q.as_sync2) begin
         r_d.xcvr_enable = 1'b0;
      end
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_q               <= '0;
         r_q.state         <= rob_pkg::ROB_IDLE;
         r_q.bdd_sync1     <= 1'b1;
         r_q.bdd_sync2     <= 1'b1;
         r_q.as_sync1      <= 1'b1;
         r_q.as_sync2      <= 1'b1;
         r_q.ds_sync1      <= 1'b1;
         r_q.ds_sync2      <= 1'b1;
         r_q.chip_select_n <= '1;
         r_q.bdd_oe_n      <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   // Open-drain style: only ever pulls low
   assign board_data_disable_n_out  = 1'b0;
   assign board_data_disable_n_oe_n = r_q.bdd_oe_n;
   assign eprom_chip_select_n       = r_q.chip_select_n;
   assign data_xcvr_enable          = r_q.xcvr_enable;

endmodule : rob_responder

//--- verif/rob_responder_props.sv
`timescale 1ns/100ps
// *****
// Port checker
// *****
module rob_responder_props (
   input wire logic                             clk,
   input wire logic                             arst_n,
   input wire logic                             address_strobe_n,
   input wire logic                             data_strobe_n,
   input wire logic                             board_data_disable_n_in,
   input wire logic                             board_data_disable_n_out,
   input wire logic                             board_data_disable_n_oe_n,
   input wire logic [rob_pkg::SOCKET_COUNT-1:0] eprom_chip_select_n,
   input wire logic                             data_xcvr_enable
);
   // One domain; strobes pass a 2-flop sync, hence the slack
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   reset_idle_a:
      assert property ($rose(arst_n) |-> board_data_disable_n_oe_n && !data_xcvr_enable)
      else $error("Outputs active after reset");
   pull_low_a:
      assert property (board_data_disable_n_out == 1'b0)
      else $error("Disable drive level not low");
   xcvr_needs_dis_a:
      assert property (data_xcvr_enable |-> !board_data_disable_n_oe_n)
      else $error("Transceiver on while disable released");
   enable_delay_a:
      assert property ($fell(board_data_disable_n_oe_n) |->
         !data_xcvr_enable [*4] ##1 (data_xcvr_enable || board_data_disable_n_oe_n))
      else $error("Transceiver delay wrong");
   strobe_clear_a:
      assert property (address_strobe_n [*5] |-> board_data_disable_n_oe_n && !data_xcvr_enable)
      else $error("Response kept while strobe high");
   patch_hold_a:
      assert property ((!board_data_disable_n_in && board_data_disable_n_oe_n) [*5]
         |=> board_data_disable_n_oe_n && !data_xcvr_enable)
      else $error("Answered a patched location");
   ds_release_a:
      assert property ($rose(data_strobe_n) && data_xcvr_enable |=>
         data_xcvr_enable [*3] ##[1:2] !data_xcvr_enable)
      else $error("Transceiver release timing wrong");
   one_select_a:
      assert property ($onehot0(~eprom_chip_select_n))
      else $error("More than one socket selected");
endmodule : rob_responder_props

//--- verif/rob_bus_master.sv
`timescale 1ns/100ps
// *****
// Processor read cycle model
// *****
module rob_bus_master (
   input  wire logic        clk,
   input  wire logic        dis_oe_n,
   input  wire logic        dis_out,
   output logic [15:0]      addr = 16'hFFFF,
   output logic             as_n = 1'b1,
   output logic             ds_n = 1'b1,
   output wire logic        dis_in
);
   logic patch_n = 1'b1;
   // Pulled-up shared line, either card may pull it low
   assign dis_in = patch_n & (dis_oe_n | dis_out);
   // Full handshake even when the overlay answers; dwell sets speed
   task automatic read(input logic [15:0] a, input logic patch, input int dwell);
      @(posedge clk);
      #1 addr = a;
      as_n = 1'b0;
      patch_n = ~patch;
      repeat (2) @(posedge clk);
      #1 ds_n = 1'b0;
      repeat (dwell) @(posedge clk);
      #1 ds_n = 1'b1;
      repeat (6) @(posedge clk);
      #1 as_n = 1'b1;
      addr = ~a; // Released bus does not hold its value
      patch_n = 1'b1;
   endtask : read
endmodule : rob_bus_master

//--- verif/rob_responder_bench.sv
`timescale 1ns/100ps
// *****
// Bench top
// *****
module rob_responder_bench;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [8:0]  straps = 9'h1FB; // Sockets 3 and 4 empty
   logic [15:0] addr, cs_n;
   logic        as_n, ds_n, dis_in, dis_out, dis_oe_n, xcvr;
   int          err_total = 0;
   int          tests_run = 0;
   int          cycles = 0;
   always #20 clk = ~clk;
   // Hang guard, run needs about 220 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         err_total = err_total + 1;
         tally_and_finish();
      end
   end
   rob_bus_master u_cpu (.clk, .dis_oe_n, .dis_out, .addr, .as_n, .ds_n, .dis_in);
   rob_responder u_dut (.clk, .arst_n, .bus_addr(addr), .address_strobe_n(as_n),
      .data_strobe_n(ds_n), .board_data_disable_n_in(dis_in), .eprom_presence_straps(straps),
      .address_placement_strap_a(1'b0), .address_placement_strap_b(1'b0),
      .address_placement_strap_c(1'b0), .board_data_disable_n_out(dis_out),
      .board_data_disable_n_oe_n(dis_oe_n), .eprom_chip_select_n(cs_n), .data_xcvr_enable(xcvr));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Read with mid-cycle look at {oe_n, xcvr}
   task automatic probe(input logic [15:0] a, input logic p, input int dwell, input int at,
                        input logic [15:0] exp);
      fork
         u_cpu.read(a, p, dwell);
         begin
            repeat (at) @(posedge clk);
            #1 check({14'h0, dis_oe_n, xcvr}, exp);
            check(cs_n, ~(16'h0001 << a[14:11]));
         end
      join
      check({14'h0, dis_oe_n, xcvr}, 16'h0002);
   endtask : probe
   // Back-to-back sweep, ROM 0 single socket then pairs
   task automatic t_sweep();
      for (int s = 0; s < 8; s++) begin
         probe(16'(s << 11), 1'b0, 10, 10, straps[(s + 1) / 2] ? 16'h0001 : 16'h0002);
      end
   endtask : t_sweep
   initial begin
      repeat (2) @(posedge clk);
      #1 arst_n = 1'b1;
      check(cs_n, 16'hFFFF);
      check({14'h0, dis_oe_n, xcvr}, 16'h0002);
      t_sweep();
      probe(16'h0800, 1'b1, 10, 10, 16'h0002);
      probe(16'h1000, 1'b0, 40, 40, 16'h0001);
      tally_and_finish();
   end
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
endmodule : rob_responder_bench
bind rob_responder rob_responder_props u_props (.clk, .arst_n, .address_strobe_n,
   .data_strobe_n, .board_data_disable_n_in, .board_data_disable_n_out,
   .board_data_disable_n_oe_n, .eprom_chip_select_n, .data_xcvr_enable);
